/* shared/umh_pkg.sv */
// Constants for the modem handshake and host pin block
// Assumes a 25 MHz system clock and a byte-wide register port
`default_nettype none
package umh_pkg;

  localparam int unsigned ADDR_W        = 3;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned CLK_PERIOD_NS = 40;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [2:0] OFS_IRQ_EN  = 3'h1;
  localparam logic [2:0] OFS_IRQ_ID  = 3'h2;
  localparam logic [2:0] OFS_MDM_CTL = 3'h4;
  localparam logic [2:0] OFS_MDM_STA = 3'h6;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned IE_RX_AVAIL_BIT = 0;
  localparam int unsigned IE_TX_EMPTY_BIT = 1;
  localparam int unsigned IE_RX_ERR_BIT   = 2;
  localparam int unsigned IE_MODEM_BIT    = 3;
  localparam int unsigned MC_TERM_BIT     = 0;
  localparam int unsigned MC_USER1_BIT    = 2;
  localparam int unsigned MC_USER2_BIT    = 3;
  localparam int unsigned MC_LOOP_BIT     = 4;
  localparam int unsigned MS_DSR_CHG_BIT  = 1;
  localparam int unsigned MS_CD_CHG_BIT   = 3;
  localparam int unsigned MS_DSR_BIT      = 5;
  localparam int unsigned MS_CD_BIT       = 7;

  //////////////////////////////////////////////////////////////////////////////
  // Writable masks and reset values
  localparam logic [7:0] IRQ_EN_MASK  = 8'h0F;
  localparam logic [7:0] MDM_CTL_MASK = 8'h1D;
  localparam logic [7:0] IRQ_EN_RST   = 8'h00;
  localparam logic [7:0] MDM_CTL_RST  = 8'h00;
  localparam logic [7:0] RDATA_IDLE   = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Receiver clock: 16 edges per bit time
  localparam int unsigned RX_OVERSAMPLE = 16;
  localparam int unsigned RX_DIV_W      = 4;
  localparam logic [3:0]  RX_DIV_LAST   = 4'(RX_OVERSAMPLE - 1);

endpackage
`default_nettype wire

/* rtl/umh_status_bit.sv */
// One modem status input: inverted mirror plus sticky change flag
// Assumes the pin is synchronous to i_clk_sys
`timescale 1ns/1ps
`default_nettype none
module umh_status_bit (
  input  wire logic i_clk_sys,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  input  wire logic i_master_reset,
  input  wire logic i_level_n,
  input  wire logic i_read_clr,
  output logic      o_level,
  output logic      o_changed
);

  logic primed_r;
  logic edge_seen;

  assign edge_seen = primed_r && (i_level_n == o_level);

  ////////////////////////////////////////////////////////////////////////////////
  // Mirror of the pin, complemented
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_level  <= 1'b0;
      primed_r <= 1'b0;
    end else if (i_ce) begin
      o_level  <= ~i_level_n;
      primed_r <= ~i_master_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Change flag; a new change beats the read clear
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_changed <= 1'b0;
    end else if (i_ce) begin
      if (i_master_reset) begin
        o_changed <= 1'b0;
      end else if (edge_seen) begin
        o_changed <= 1'b1; // R2
      end else if (i_read_clr) begin
        o_changed <= 1'b0; // R21
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_change_sets;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_ce && !i_master_reset && primed_r && (i_level_n == o_level)) |=> o_changed;
  endproperty
  a_change_sets: assert property (p_change_sets) else $error("change flag not set"); // R2

  property p_read_clears;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_ce && i_read_clr && !edge_seen) |=> !o_changed;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("change flag not cleared"); // R21

endmodule
`default_nettype wire

/* rtl/umh_core.sv */
// Modem handshake, interrupt pin and host read pins of a serial controller
// Assumes all pins synchronous to i_clk_sys; serial path lives elsewhere
//
// Overview of operation
// R1: Modem status bit 7 reads as the inverse of the carrier detect pin.
// R2: Status bit 3 flags a carrier detect change since the last status read.
// R3: Carrier detect never influences receiver timing or operation.
// R4: A carrier detect change raises the interrupt when modem interrupts are enabled.
// R5: Modem status bit 5 reads as the inverse of the set ready pin.
// R6: Status bit 1 flags a set ready change since the last status read.
// R7: A set ready change raises the interrupt when modem interrupts are enabled.
// R8: Driver disable goes low while the host reads from the block.
// R9: Terminal ready pin is low when control bit 0 is one.
// R10: First user output is low when control bit 2 is one.
// R11: Second user output is low when control bit 3 is one.
// R12: Master reset drives terminal ready and both user outputs high.
// R13: Loopback holds terminal ready and both user outputs high.
// R14: Interrupt pin is high while any enabled interrupt source is active.
// R15: Interrupt pin drops once serviced, or on master reset.
// R16: Master reset clears control logic and registers, not data or divisor.
// R17: Receiver timing is taken from the 16x receiver clock input.
// R18: Either read strobe polarity returns register data while selected.
// R19: Host ties the unused read strobe inactive.
// R20: Host selects with a, b high and c low; strobe latches it.
// R21: Reading modem status clears both change flags.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module umh_core (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_master_reset,
  input  wire logic [2:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_rd_n,
  input  wire logic        i_select_a,
  input  wire logic        i_select_b,
  input  wire logic        i_select_c_n,
  input  wire logic        i_addr_strobe_n,
  input  wire logic        i_carrier_detect_n,
  input  wire logic        i_set_ready_n,
  input  wire logic        i_rclk,
  input  wire logic        i_rx_error,
  input  wire logic        i_rx_avail,
  input  wire logic        i_tx_empty,
  output logic [7:0]       o_rdata,
  output logic             o_driver_disable_n,
  output logic             o_irq_out,
  output logic             o_terminal_ready_n,
  output logic             o_user_out1_n,
  output logic             o_user_out2_n,
  output logic             o_rx_sample_tick
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic f_hit(input logic [2:0] addr, input logic [2:0] ofs);
    f_hit = (addr == ofs);
  endfunction

  logic       sel_latched_r;
  logic       sel_live;
  logic       selected;
  logic       rd_req;
  logic       wr_req;
  logic       rd_msr;
  logic [7:0] irq_enable_reg_r;
  logic [7:0] mdm_ctl_r;
  logic       carrier_level;
  logic       carrier_chg;
  logic       dsr_level;
  logic       dsr_chg;
  logic       modem_pend;
  logic       any_pend;
  logic [7:0] msr_view;
  logic [7:0] iid_view;
  logic [7:0] rdata_nxt;
  logic       rclk_q_r;
  logic       rclk_rise;
  logic [3:0] rx_div_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Chip select and strobes
  assign sel_live = i_select_a && i_select_b && !i_select_c_n; // R20

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_latched_r <= 1'b0;
    end else if (i_ce && !i_addr_strobe_n) begin
      sel_latched_r <= sel_live; // R20
    end
  end

  assign selected = i_addr_strobe_n ? sel_latched_r : sel_live;
  assign rd_req   = selected && (i_rd || !i_rd_n); // R18 R19
  assign wr_req   = selected && i_wr;
  assign rd_msr   = rd_req && f_hit(i_addr, umh_pkg::OFS_MDM_STA);

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt enable register
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_enable_reg_r <= umh_pkg::IRQ_EN_RST;
    end else if (i_ce) begin
      if (i_master_reset) begin
        irq_enable_reg_r <= umh_pkg::IRQ_EN_RST; // R16
      end else if (wr_req && f_hit(i_addr, umh_pkg::OFS_IRQ_EN)) begin
        irq_enable_reg_r <= i_wdata & umh_pkg::IRQ_EN_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Modem control register
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      mdm_ctl_r <= umh_pkg::MDM_CTL_RST;
    end else if (i_ce) begin
      if (i_master_reset) begin
        mdm_ctl_r <= umh_pkg::MDM_CTL_RST; // R16
      end else if (wr_req && f_hit(i_addr, umh_pkg::OFS_MDM_CTL)) begin
        mdm_ctl_r <= i_wdata & umh_pkg::MDM_CTL_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Modem status inputs
  umh_status_bit u_carrier (
    .i_clk_sys      (i_clk_sys),
    .i_nrst         (i_nrst),
    .i_ce           (i_ce),
    .i_master_reset (i_master_reset),
    .i_level_n      (i_carrier_detect_n),
    .i_read_clr     (rd_msr),
    .o_level        (carrier_level),
    .o_changed      (carrier_chg)
  );

  umh_status_bit u_dsr (
    .i_clk_sys      (i_clk_sys),
    .i_nrst         (i_nrst),
    .i_ce           (i_ce),
    .i_master_reset (i_master_reset),
    .i_level_n      (i_set_ready_n),
    .i_read_clr     (rd_msr),
    .o_level        (dsr_level),
    .o_changed      (dsr_chg)
  );

  always_comb begin
    msr_view                            = 8'h00;
    msr_view[umh_pkg::MS_CD_BIT]        = carrier_level; // R1
    msr_view[umh_pkg::MS_CD_CHG_BIT]    = carrier_chg;   // R2
    msr_view[umh_pkg::MS_DSR_BIT]       = dsr_level; // R5
    msr_view[umh_pkg::MS_DSR_CHG_BIT]   = dsr_chg;   // R6
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt sources
  assign modem_pend = irq_enable_reg_r[umh_pkg::IE_MODEM_BIT] && (carrier_chg || dsr_chg); // R4 R7
  assign any_pend   = modem_pend
                   || (irq_enable_reg_r[umh_pkg::IE_RX_AVAIL_BIT] && i_rx_avail)
                   || (irq_enable_reg_r[umh_pkg::IE_TX_EMPTY_BIT] && i_tx_empty)
                   || (irq_enable_reg_r[umh_pkg::IE_RX_ERR_BIT] && i_rx_error); // R14

  always_comb begin
    iid_view                           = 8'h00;
    iid_view[umh_pkg::IE_RX_AVAIL_BIT] = i_rx_avail;
    iid_view[umh_pkg::IE_TX_EMPTY_BIT] = i_tx_empty;
    iid_view[umh_pkg::IE_RX_ERR_BIT]   = i_rx_error;
    iid_view[umh_pkg::IE_MODEM_BIT]    = carrier_chg || dsr_chg;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq_out <= 1'b0;
    end else if (i_ce) begin
      if (i_master_reset) begin
        o_irq_out <= 1'b0; // R15
      end else begin
        o_irq_out <= any_pend; // R14 R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    rdata_nxt = umh_pkg::RDATA_IDLE;
    if (rd_req) begin
      case (i_addr)
        umh_pkg::OFS_IRQ_EN:  rdata_nxt = irq_enable_reg_r;
        umh_pkg::OFS_IRQ_ID:  rdata_nxt = iid_view;
        umh_pkg::OFS_MDM_CTL: rdata_nxt = mdm_ctl_r;
        umh_pkg::OFS_MDM_STA: rdata_nxt = msr_view; // R1 R5
        default:              rdata_nxt = umh_pkg::RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= umh_pkg::RDATA_IDLE;
    end else if (i_ce) begin
      o_rdata <= rdata_nxt; // R18
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_driver_disable_n <= 1'b1;
    end else if (i_ce) begin
      o_driver_disable_n <= !rd_req; // R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Modem control pins
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_terminal_ready_n <= 1'b1;
      o_user_out1_n      <= 1'b1;
      o_user_out2_n      <= 1'b1;
    end else if (i_ce) begin
      if (i_master_reset || mdm_ctl_r[umh_pkg::MC_LOOP_BIT]) begin
        o_terminal_ready_n <= 1'b1; // R12 R13
        o_user_out1_n      <= 1'b1; // R12 R13
        o_user_out2_n      <= 1'b1; // R12 R13
      end else begin
        o_terminal_ready_n <= !mdm_ctl_r[umh_pkg::MC_TERM_BIT];  // R9
        o_user_out1_n      <= !mdm_ctl_r[umh_pkg::MC_USER1_BIT]; // R10
        o_user_out2_n      <= !mdm_ctl_r[umh_pkg::MC_USER2_BIT]; // R11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver timing from its own clock input only
  assign rclk_rise = i_rclk && !rclk_q_r;

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rclk_q_r <= 1'b0;
    end else if (i_ce) begin
      rclk_q_r <= i_rclk;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_div_r         <= '0;
      o_rx_sample_tick <= 1'b0;
    end else if (i_ce) begin
      if (i_master_reset) begin
        rx_div_r         <= '0; // R16
        o_rx_sample_tick <= 1'b0;
      end else begin
        o_rx_sample_tick <= rclk_rise && (rx_div_r == umh_pkg::RX_DIV_LAST); // R17 R3
        if (rclk_rise) begin
          rx_div_r <= rx_div_r + 4'h1; // R17
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_carrier_mirror;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_ce && $past(i_ce) && rd_msr)
        |=> (o_rdata[umh_pkg::MS_CD_BIT] == !$past(i_carrier_detect_n, 2));
  endproperty
  a_carrier_mirror: assert property (p_carrier_mirror) else $error("carrier bit not inverse of pin"); // R1

  property p_dsr_mirror;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_ce && $past(i_ce) && rd_msr) |=> (o_rdata[umh_pkg::MS_DSR_BIT] == !$past(i_set_ready_n, 2));
  endproperty
  a_dsr_mirror: assert property (p_dsr_mirror) else $error("set ready bit not inverse of pin"); // R5

  property p_carrier_irq;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_ce && !i_master_reset && irq_enable_reg_r[umh_pkg::IE_MODEM_BIT] && carrier_chg) |=> o_irq_out;
  endproperty
  a_carrier_irq: assert property (p_carrier_irq) else $error("carrier change raised no interrupt"); // R4

  property p_dsr_irq;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_ce && !i_master_reset && irq_enable_reg_r[umh_pkg::IE_MODEM_BIT] && dsr_chg) |=> o_irq_out;
  endproperty
  a_dsr_irq: assert property (p_dsr_irq) else $error("set ready change raised no interrupt"); // R7

  property p_irq_drop;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_ce && (i_master_reset || !any_pend)) |=> !o_irq_out;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("interrupt pin stuck high"); // R15

  property p_drv_dis;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce |=> (o_driver_disable_n == !$past(rd_req));
  endproperty
  a_drv_dis: assert property (p_drv_dis) else $error("driver disable not following read"); // R8

  property p_term_ready;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_ce && !i_master_reset && !mdm_ctl_r[umh_pkg::MC_LOOP_BIT] && mdm_ctl_r[umh_pkg::MC_TERM_BIT])
        |=> !o_terminal_ready_n;
  endproperty
  a_term_ready: assert property (p_term_ready) else $error("terminal ready not active"); // R9

  property p_user_outs;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_ce && !i_master_reset && !mdm_ctl_r[umh_pkg::MC_LOOP_BIT])
        |=> (o_user_out1_n == !$past(mdm_ctl_r[umh_pkg::MC_USER1_BIT]))
            && (o_user_out2_n == !$past(mdm_ctl_r[umh_pkg::MC_USER2_BIT]));
  endproperty
  a_user_outs: assert property (p_user_outs) else $error("user outputs wrong"); // R10 R11

  sequence s_forced_idle;
    o_terminal_ready_n && o_user_out1_n && o_user_out2_n;
  endsequence

  property p_loop_idle;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_ce && mdm_ctl_r[umh_pkg::MC_LOOP_BIT]) |=> s_forced_idle;
  endproperty
  a_loop_idle: assert property (p_loop_idle) else $error("loopback left a pin active"); // R13

  property p_mreset_idle;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_ce && i_master_reset)
        |=> (s_forced_idle and (mdm_ctl_r == umh_pkg::MDM_CTL_RST && irq_enable_reg_r == umh_pkg::IRQ_EN_RST));
  endproperty
  a_mreset_idle: assert property (p_mreset_idle) else $error("master reset left state set"); // R12 R16

  // Tick lasts one cycle unless the enable froze it
  sequence s_tick_pulse;
    o_rx_sample_tick ##1 (!o_rx_sample_tick || !$past(i_ce));
  endsequence

  property p_rx_tick;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_ce && !i_master_reset && rclk_rise && rx_div_r == umh_pkg::RX_DIV_LAST) |=> s_tick_pulse;
  endproperty
  a_rx_tick: assert property (p_rx_tick) else $error("receiver tick missing"); // R17

  property p_idle_rdata;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (i_ce && !rd_req) |=> (o_rdata == umh_pkg::RDATA_IDLE);
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside read cycle"); // R18

endmodule
`default_nettype wire

/* tb/umh_modem_model.sv */
// Modem or data set model: drives carrier detect and set ready levels
// Assumes the bench calls set_lines just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module umh_modem_model (
  input  wire logic i_clk_sys,
  input  wire logic i_terminal_ready_n,
  output logic      o_carrier_detect_n,
  output logic      o_set_ready_n
);
  int term_active_cycles = 0;

  // Counts cycles in which the terminal side asks for the link
  always @(posedge i_clk_sys) begin
    if (!i_terminal_ready_n) begin
      term_active_cycles <= term_active_cycles + 1;
    end
  end

  initial begin
    o_carrier_detect_n = 1'b1;
    o_set_ready_n      = 1'b1;
  end

  // Pin levels are static between changes
  task automatic set_lines(input logic cd_n, input logic sr_n);
    o_carrier_detect_n <= cd_n;
    o_set_ready_n      <= sr_n;
  endtask
endmodule
`default_nettype wire

/* tb/uart_modem_handshake_host_pins_tb_top.sv */
// Self-checking bench for the modem handshake block
// Assumes umh_pkg compiled first; modem model on the status pins
`timescale 1ns/1ps
`default_nettype none
module uart_modem_handshake_host_pins_tb_top;
  typedef struct packed {
    logic       cd_n;
    logic       sr_n;
    logic [7:0] mc;
    logic [7:0] st;
    logic [2:0] pins;
    logic       irq;
  } umh_row_s;

  logic       i_clk_sys = 1'b0;
  logic       i_nrst = 1'b0;
  logic       mrst = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       rd_n = 1'b1;
  logic       ce = 1'b1;
  logic       sel_a = 1'b1;
  logic       sel_b = 1'b1;
  logic       sel_c_n = 1'b0;
  logic       astb_n = 1'b0;
  logic       rclk = 1'b0;
  logic [2:0] src = 3'h0;
  logic       cd_n;
  logic       sr_n;
  logic [7:0] o_rdata;
  logic       drv_dis_n;
  logic       irq;
  logic       term_n;
  logic       u1_n;
  logic       u2_n;
  logic       tick;
  int         bad_count = 0;
  int         samples_checked = 0;
  int         ticks;
  umh_row_s   rows [7];

  always #20 i_clk_sys = ~i_clk_sys;

  umh_core u_dut (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(ce), .i_master_reset(mrst),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_rd_n(rd_n),
    .i_select_a(sel_a), .i_select_b(sel_b), .i_select_c_n(sel_c_n), .i_addr_strobe_n(astb_n),
    .i_carrier_detect_n(cd_n), .i_set_ready_n(sr_n), .i_rclk(rclk),
    .i_rx_error(src[2]), .i_rx_avail(src[0]), .i_tx_empty(src[1]),
    .o_rdata(o_rdata), .o_driver_disable_n(drv_dis_n), .o_irq_out(irq),
    .o_terminal_ready_n(term_n), .o_user_out1_n(u1_n), .o_user_out2_n(u2_n),
    .o_rx_sample_tick(tick)
  );

  umh_modem_model u_modem (
    .i_clk_sys(i_clk_sys), .i_terminal_ready_n(term_n),
    .o_carrier_detect_n(cd_n), .o_set_ready_n(sr_n)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_clk_sys);
    wr    <= 1'b0;
  endtask

  // One strobe only; the other stays inactive
  task automatic rd_chk(input logic [2:0] a, input logic use_n, input logic [7:0] exp, input logic dd);
    @(posedge i_clk_sys);
    addr <= a;
    if (use_n) begin
      rd_n <= 1'b0;
    end else begin
      rd <= 1'b1;
    end
    @(posedge i_clk_sys);
    rd   <= 1'b0;
    rd_n <= 1'b1;
    #1;
    check(o_rdata, exp);
    check({7'h00, drv_dis_n}, {7'h00, dd});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{1'b1, 1'b1, 8'h00, 8'h00, 3'h7, 1'b0};
    rows[1] = '{1'b0, 1'b1, 8'h01, 8'h88, 3'h3, 1'b1};
    rows[2] = '{1'b0, 1'b0, 8'h04, 8'hA2, 3'h5, 1'b1};
    rows[3] = '{1'b1, 1'b1, 8'h08, 8'h0A, 3'h6, 1'b1};
    rows[4] = '{1'b1, 1'b1, 8'h0D, 8'h00, 3'h0, 1'b0};
    rows[5] = '{1'b0, 1'b1, 8'h1D, 8'h88, 3'h7, 1'b1};
    rows[6] = '{1'b0, 1'b1, 8'hFF, 8'h80, 3'h7, 1'b0};
    repeat (6) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    #1;
    check({3'h0, irq, drv_dis_n, term_n, u1_n, u2_n}, 8'h0F);
    check(o_rdata | {7'h00, tick}, 8'h00);
    wr_reg(umh_pkg::OFS_IRQ_EN, 8'hF8);
    rd_chk(umh_pkg::OFS_IRQ_EN, 1'b0, 8'h08, 1'b0);
    foreach (rows[i]) begin
      @(posedge i_clk_sys);
      u_modem.set_lines(rows[i].cd_n, rows[i].sr_n);
      wr_reg(umh_pkg::OFS_MDM_CTL, rows[i].mc);
      wait_cyc(4);
      check({5'h00, term_n, u1_n, u2_n}, {5'h00, rows[i].pins});
      check({7'h00, irq}, {7'h00, rows[i].irq});
      rd_chk(umh_pkg::OFS_MDM_STA, i[0], rows[i].st, 1'b0);
      wait_cyc(1);
      check({7'h00, irq}, 8'h00);
      rd_chk(umh_pkg::OFS_MDM_CTL, 1'b0, rows[i].mc & umh_pkg::MDM_CTL_MASK, 1'b0);
      rd_chk(umh_pkg::OFS_MDM_STA, 1'b1, rows[i].st & 8'hA0, 1'b0);
    end
    // Unmapped address, then selection latched by the strobe
    rd_chk(3'h7, 1'b0, 8'h00, 1'b0);
    @(posedge i_clk_sys);
    astb_n <= 1'b1;
    sel_a  <= 1'b0;
    rd_chk(umh_pkg::OFS_MDM_CTL, 1'b0, 8'h1D, 1'b0);
    @(posedge i_clk_sys);
    astb_n <= 1'b0;
    rd_chk(umh_pkg::OFS_MDM_CTL, 1'b1, 8'h00, 1'b1);
    wr_reg(umh_pkg::OFS_MDM_CTL, 8'h00);
    @(posedge i_clk_sys);
    sel_a <= 1'b1;
    rd_chk(umh_pkg::OFS_MDM_CTL, 1'b0, 8'h1D, 1'b0);
    // Master reset in mid-run with outputs active
    wr_reg(umh_pkg::OFS_MDM_CTL, 8'h0D);
    u_modem.set_lines(1'b1, 1'b0);
    wait_cyc(4);
    check({4'h0, irq, term_n, u1_n, u2_n}, 8'h08);
    @(posedge i_clk_sys);
    mrst <= 1'b1;
    @(posedge i_clk_sys);
    mrst <= 1'b0;
    #1;
    check({4'h0, irq, term_n, u1_n, u2_n}, 8'h07);
    rd_chk(umh_pkg::OFS_MDM_CTL, 1'b0, 8'h00, 1'b0);
    rd_chk(umh_pkg::OFS_IRQ_EN, 1'b0, 8'h00, 1'b0);
    rd_chk(umh_pkg::OFS_MDM_STA, 1'b0, 8'h20, 1'b0);
    // Serial path interrupt sources one at a time
    wr_reg(umh_pkg::OFS_IRQ_EN, 8'h0F);
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk_sys);
      src <= 3'(1 << k);
      wait_cyc(3);
      check({7'h00, irq}, 8'h01);
      rd_chk(umh_pkg::OFS_IRQ_ID, 1'b0, 8'(1 << k), 1'b0);
      @(posedge i_clk_sys);
      src <= 3'h0;
      wait_cyc(3);
      check({7'h00, irq}, 8'h00);
    end
    wr_reg(umh_pkg::OFS_IRQ_EN, 8'h00);
    // Receiver clock: 32 rising edges give two ticks, carrier toggling meanwhile
    ticks = 0;
    for (int n = 0; n < 70; n++) begin
      @(posedge i_clk_sys);
      if (n < 64) rclk <= ~rclk;
      if (n == 20) u_modem.set_lines(1'b0, 1'b0);
      if (n == 40) u_modem.set_lines(1'b1, 1'b0);
      #1;
      if (tick === 1'b1) ticks++;
    end
    check(8'(ticks), 8'h02);
    check({7'h00, irq}, 8'h00);
    check({7'h00, u_modem.term_active_cycles > 0}, 8'h01);
    // Remaining select inputs, then clock enable low freezes a write
    @(posedge i_clk_sys);
    sel_c_n <= 1'b1;
    rd_chk(umh_pkg::OFS_MDM_STA, 1'b0, 8'h00, 1'b1);
    @(posedge i_clk_sys);
    sel_c_n <= 1'b0;
    sel_b   <= 1'b0;
    rd_chk(umh_pkg::OFS_MDM_STA, 1'b1, 8'h00, 1'b1);
    @(posedge i_clk_sys);
    sel_b <= 1'b1;
    ce    <= 1'b0;
    wr_reg(umh_pkg::OFS_MDM_CTL, 8'h0D);
    wait_cyc(2);
    check({5'h00, term_n, u1_n, u2_n}, 8'h07);
    @(posedge i_clk_sys);
    ce <= 1'b1;
    rd_chk(umh_pkg::OFS_MDM_CTL, 1'b0, 8'h00, 1'b0);
    rd_chk(umh_pkg::OFS_MDM_STA, 1'b0, 8'h28, 1'b0);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
